// >>> verilog/spic_top.sv
// Two-socket power, reset and interrupt routing control with Avalon slave
//
// Overview of operation
// (R1) Two sockets, second 0x40 higher, aliased window
// (R2) Output enable bit gates card outputs
// (R3) Default layout: bits 6,3,2 read zero
// (R4) Default layout bit 5: auto power switching
// (R5) Default bit 4 enables Vcc, system selects
// (R6) Vpp field: none, Vcc, 12 V, reserved
// (R7) Vpp ignored while Vcc is off
// (R8) Alternate layout bits 4..3 request Vcc
// (R9) Alternate layout bits 6..5 read zero
// (R10) Alternate layout bit 2 reads zero
// (R11) Revision 0010b selects alternate layout
// (R12) Status bit 6 shows socket power
// (R13) General bit 7 enables ring indicate
// (R14) General bit 6 clear holds card reset
// (R15) General bit 5 records memory or I/O
// (R16) Bit 4 routes status change to PCI
// (R17) Select zero: no irq, status change to PCI
// (R18) Bits 3..0 select functional interrupt line
// (R19) Reserved writes are discarded
// (R20) Output enable clear floats card drivers
`timescale 1ns/1ps
`default_nettype none

module spic_top
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [13:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [3:0] CARD_DETECT_N,
  input wire logic [1:0] BATTERY_RING_IN,
  input wire logic [1:0] CARD_IREQ_N,
  output logic [1:0] CARD_OE_N,
  output logic [1:0] CARD_RESET,
  output logic [1:0] VCC_ON,
  output logic [1:0] VCC_SEL_3V3,
  output logic [3:0] VPP_SEL,
  output logic [1:0] RING_INDICATE,
  output logic [1:0] CSC_TO_PCI,
  output logic [7:0] CSC_IRQ_SEL,
  output logic [15:0] IRQ_LINES
);

  // ==========================================================================
  // Decode helpers
  // True when an index lands on a socket register, directly or aliased
  function automatic logic sock_hit(input logic [11:0] idx);
    logic [5:0] off;
    off = idx[spic_pkg::OFF_W-1:0];
    sock_hit = (idx[10:7] == spic_pkg::WIN_ZERO) &&
      (off == spic_pkg::IDX_ID || off == spic_pkg::IDX_STAT ||
       off == spic_pkg::IDX_PWR || off == spic_pkg::IDX_IGC ||
       off == spic_pkg::IDX_CSCFG);
  endfunction

  // One-hot line for a functional select code; code zero gives nothing
  function automatic logic [15:0] irq_line(input logic [3:0] sel,
                                           input logic act);
    irq_line = '0;
    if (act && sel != spic_pkg::FSEL_NONE)
      irq_line[sel] = 1'b1;
  endfunction

  // ==========================================================================
  // Bus side signals
  logic wait_r; // Waitrequest, low for exactly one cycle per access
  logic [31:0] rdata_r; // Read data, loaded the cycle before the answer
  logic [7:0] sysctl_r; // System control, only the Vcc select bit lives
  logic [11:0] idx; // Word index of the current request
  logic [5:0] offset; // Offset inside a socket window
  logic sock_sel; // Socket B when set
  logic req; // Read or write pending
  logic wr_commit; // Write takes effect at this edge
  logic [7:0] rd_byte; // Selected read value
  logic [1:0] sock_wr; // Per-socket write strobe
  logic [7:0] sock_rdata [spic_pkg::NSOCK]; // Per-socket read value
  spic_pkg::spic_sock_ctrl_t ctrl [spic_pkg::NSOCK]; // Decoded controls

  assign idx = AVS_ADDRESS[13:2];
  assign offset = idx[spic_pkg::OFF_W-1:0];
  assign sock_sel = idx[spic_pkg::SOCK_BIT]; // [R1]
  assign req = AVS_READ | AVS_WRITE;
  // Only lane 0 carries register data; other lanes are ignored
  assign wr_commit = AVS_WRITE & ~wait_r & AVS_BYTEENABLE[0];

  // Route a committed write to the addressed socket copy
  always_comb
  begin
    sock_wr = '0;
    if (wr_commit && sock_hit(idx))
      sock_wr[sock_sel] = 1'b1; // [R1]
  end

  // Read mux; unmapped addresses answer zero
  always_comb
  begin
    rd_byte = spic_pkg::REG_RESET;
    if (sock_hit(idx))
      rd_byte = sock_rdata[sock_sel]; // [R1]
    else if (idx == spic_pkg::IDX_SYSCTL)
      rd_byte = sysctl_r;
  end

  // ==========================================================================
  // Avalon handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      wait_r <= 1'b1;
    else if (req && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // Read data is captured while waitrequest is still high
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      rdata_r <= '0;
    else if (AVS_READ && wait_r)
      rdata_r <= {spic_pkg::RD_PAD, rd_byte};
  end

  // System control; reserved bits are dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      sysctl_r <= spic_pkg::REG_RESET;
    else if (wr_commit && idx == spic_pkg::IDX_SYSCTL)
      sysctl_r <= AVS_WRITEDATA[7:0] & spic_pkg::SYSCTL_MASK; // [R19]
  end

  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA = rdata_r;

  // ==========================================================================
  // Pin synchronisers; stage one feeds only stage two
  logic [7:0] sync1_r; // First stage
  logic [7:0] sync2_r; // Second stage, safe to read
  spic_pkg::spic_pin_in_t pins [spic_pkg::NSOCK]; // Per-socket pin view

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= {CARD_IREQ_N, BATTERY_RING_IN, CARD_DETECT_N};
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================================
  // Socket copies
  for (genvar s = 0; s < spic_pkg::NSOCK; s++)
  begin : g_sock
    // Seated only when both card detects are low
    assign pins[s].card_present = ~sync2_r[2*s] & ~sync2_r[2*s+1];
    assign pins[s].ring_in = sync2_r[4+s];
    assign pins[s].ireq = ~sync2_r[6+s];

    spic_socket u_sock
    (
      .clk(SYS_CLK),
      .reset(RESET),
      .wr_en(sock_wr[s]),
      .offset(offset),
      .wdata(AVS_WRITEDATA[7:0]),
      .sys_vcc_sel(sysctl_r[spic_pkg::SYS_VCC_BIT]),
      .card_present(pins[s].card_present),
      .rdata(sock_rdata[s]),
      .ctrl(ctrl[s])
    );
  end

  // ==========================================================================
  // Output registers
  logic [1:0] oe_n_r; // Card driver enables, low drives
  logic [1:0] reset_r; // Card reset level
  logic [1:0] vcc_r; // Vcc switch
  logic [1:0] v3_r; // Vcc level 3.3 V when set
  logic [3:0] vpp_r; // Vpp code per socket
  logic [1:0] ring_r; // Ring indicate seen
  logic [1:0] cscp_r; // Status change to PCI
  logic [7:0] cscs_r; // Status change select per socket
  logic [15:0] irq_r; // Functional interrupt lines

  // Card drivers float whenever the output enable bit is clear
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      oe_n_r <= '1;
    else
      for (int s = 0; s < spic_pkg::NSOCK; s++)
        oe_n_r[s] <= ~ctrl[s].out_en; // [R2] [R20]
  end

  // Card reset, held asserted from reset until general bit 6 is set
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      reset_r <= '1;
    else
      for (int s = 0; s < spic_pkg::NSOCK; s++)
        reset_r[s] <= ctrl[s].card_reset; // [R14]
  end

  // Supply switches
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      vcc_r <= '0;
      v3_r <= '0;
      vpp_r <= '0;
    end
    else
      for (int s = 0; s < spic_pkg::NSOCK; s++)
      begin
        vcc_r[s] <= ctrl[s].vcc_on; // [R5] [R8]
        v3_r[s] <= ctrl[s].vcc_3v3;
        vpp_r[2*s +: 2] <= ctrl[s].vpp; // [R7]
      end
  end

  // Ring indicate passes the shared pin only when enabled
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      ring_r <= '0;
    else
      for (int s = 0; s < spic_pkg::NSOCK; s++)
        ring_r[s] <= ctrl[s].ring_en & pins[s].ring_in; // [R13]
  end

  // Status-change routing
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      cscp_r <= '0;
      cscs_r <= '0;
    end
    else
      for (int s = 0; s < spic_pkg::NSOCK; s++)
      begin
        cscp_r[s] <= ctrl[s].csc_pci; // [R16] [R17]
        // Select field is meaningful only when not routed to PCI
        cscs_r[4*s +: 4] <= ctrl[s].csc_pci ? spic_pkg::FSEL_NONE :
          ctrl[s].csc_sel; // [R16]
      end
  end

  // Functional interrupts; both sockets may share a line, so OR them
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      irq_r <= '0;
    else
      irq_r <= irq_line(ctrl[0].func_sel, ctrl[0].io_card & pins[0].ireq) |
        irq_line(ctrl[1].func_sel, ctrl[1].io_card & pins[1].ireq); // [R18]
  end

  assign CARD_OE_N = oe_n_r;
  assign CARD_RESET = reset_r;
  assign VCC_ON = vcc_r;
  assign VCC_SEL_3V3 = v3_r;
  assign VPP_SEL = vpp_r;
  assign RING_INDICATE = ring_r;
  assign CSC_TO_PCI = cscp_r;
  assign CSC_IRQ_SEL = cscs_r;
  assign IRQ_LINES = irq_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  logic rd_done; // Read answered this cycle
  logic wr_pwr_a; // Committed write to socket A power control
  logic wr_igc_a; // Committed write to socket A general control
  assign rd_done = AVS_READ & ~wait_r;
  assign wr_pwr_a = sock_wr[0] && offset == spic_pkg::IDX_PWR;
  assign wr_igc_a = sock_wr[0] && offset == spic_pkg::IDX_IGC;

  AST_WAIT_LOW: assert property (req && wait_r |=> !AVS_WAITREQUEST)
    else $error("waitrequest did not drop after request");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_OE_OFF: assert property ( // [R2] [R20]
    wr_pwr_a && !AVS_WRITEDATA[7] |=> ##1 CARD_OE_N[0])
    else $error("card drivers not floated after enable cleared");
  AST_PWR_RSVD: assert property ( // [R3] [R9] [R10] [R19]
    rd_done && sock_hit(idx) && offset == spic_pkg::IDX_PWR
    |-> AVS_READDATA[6] == 1'b0 && AVS_READDATA[2] == 1'b0)
    else $error("reserved power bit read nonzero");
  AST_PWR_LAYOUT: assert property ( // [R3] [R9] [R11]
    rd_done && sock_hit(idx) && offset == spic_pkg::IDX_PWR
    |-> (ctrl[sock_sel].alt ? !AVS_READDATA[5] : !AVS_READDATA[3]))
    else $error("layout reserved bit read nonzero");
  AST_VPP_GATE: assert property (!VCC_ON[0] |-> VPP_SEL[1:0] == 2'h0)
    else $error("Vpp driven while Vcc off"); // [R7]
  AST_VPP_RSVD: assert property ( // [R6]
    VPP_SEL[1:0] != spic_pkg::VPP_RSVD && VPP_SEL[3:2] != spic_pkg::VPP_RSVD)
    else $error("reserved Vpp code driven");
  AST_RESET_REL: assert property ( // [R14]
    wr_igc_a && AVS_WRITEDATA[6] |=> ##1 !CARD_RESET[0])
    else $error("card reset not released");
  AST_CSC_ROUTE: assert property ( // [R16] [R17]
    wr_igc_a && (AVS_WRITEDATA[4] || AVS_WRITEDATA[3:0] == 4'h0)
    |=> ##1 CSC_TO_PCI[0] && CSC_IRQ_SEL[3:0] == 4'h0)
    else $error("status change not routed to PCI");
  AST_IRQ_NONE: assert property (!IRQ_LINES[0]) // [R17] [R18]
    else $error("select code zero raised a line");
  AST_STATUS_PWR: assert property ( // [R12]
    rd_done && sock_hit(idx) && offset == spic_pkg::IDX_STAT
    |-> AVS_READDATA[6] == VCC_ON[sock_sel])
    else $error("power status disagrees with Vcc switch");

  COV_ALT_MODE: cover property (ctrl[0].alt && VCC_ON[0] && VCC_SEL_3V3[0]);
  COV_AUTO_OFF: cover property (wr_pwr_a ##2 !VCC_ON[0] ##1 VCC_ON[0]);
  COV_IRQ: cover property (|IRQ_LINES);
  COV_SOCK_B: cover property (sock_wr[1] ##2 !CARD_OE_N[1]);

endmodule

`default_nettype wire

// >>> inc/spic_pkg.sv
// Shared constants, register layout and carrier types of the socket block
package spic_pkg;

  // ==========================================================================
  // Bus and map geometry
  localparam int NSOCK = 2;
  localparam int NIRQ = 16;
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int OFF_W = 6;
  localparam int SOCK_BIT = 6;
  localparam int ALIAS_BIT = 11;
  localparam logic [3:0] WIN_ZERO = 4'h0;
  localparam logic [23:0] RD_PAD = 24'h000000;

  // ==========================================================================
  // Register indices inside one socket window, and the system control index (byte address is 4 x index)
  localparam logic [OFF_W-1:0] IDX_ID = 6'h00;
  localparam logic [OFF_W-1:0] IDX_STAT = 6'h01;
  localparam logic [OFF_W-1:0] IDX_PWR = 6'h02;
  localparam logic [OFF_W-1:0] IDX_IGC = 6'h03;
  localparam logic [OFF_W-1:0] IDX_CSCFG = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SYSCTL = 12'h080;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ID_RESET = 8'h84;
  localparam logic [7:0] ID_FIXED = 8'h80;
  localparam logic [7:0] ID_RW_MASK = 8'h3F;
  localparam logic [3:0] COMPAT_REV = 4'h2;
  localparam logic [7:0] PWR_MASK_DEF = 8'hB3;
  localparam logic [7:0] PWR_MASK_ALT = 8'h9B;
  localparam logic [7:0] SYSCTL_MASK = 8'h04;

  // ==========================================================================
  // Field positions
  localparam int PWR_COE = 7;
  localparam int PWR_AUTO = 5;
  localparam int PWR_VCCEN = 4;
  localparam int PWR_VCC_LO = 3;
  localparam int IGC_RING = 7;
  localparam int IGC_RST = 6;
  localparam int IGC_TYPE = 5;
  localparam int IGC_CSC = 4;
  localparam int STAT_PWR = 6;
  localparam int SYS_VCC_BIT = 2;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] VPP_NONE = 2'h0;
  localparam logic [1:0] VPP_VCC = 2'h1;
  localparam logic [1:0] VPP_12V = 2'h2;
  localparam logic [1:0] VPP_RSVD = 2'h3;
  localparam logic [3:0] FSEL_NONE = 4'h0;

  // Decoded control of one socket
  typedef struct packed {
    logic alt;
    logic out_en;
    logic vcc_on;
    logic vcc_3v3;
    logic [1:0] vpp;
    logic card_reset;
    logic ring_en;
    logic io_card;
    logic csc_pci;
    logic [3:0] csc_sel;
    logic [3:0] func_sel;
  } spic_sock_ctrl_t;

  // Synchronised pin inputs of one socket
  typedef struct packed {
    logic card_present;
    logic ring_in;
    logic ireq;
  } spic_pin_in_t;

endpackage

// >>> verilog/spic_socket.sv
// Register bank and control decode of one card socket
`timescale 1ns/1ps
`default_nettype none

module spic_socket
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [5:0] offset,
  input wire logic [7:0] wdata,
  input wire logic sys_vcc_sel,
  input wire logic card_present,
  output logic [7:0] rdata,
  output spic_pkg::spic_sock_ctrl_t ctrl
);

  // ==========================================================================
  // Storage
  logic [7:0] id_r; // Identification, revision field selects layout
  logic [7:0] pwr_r; // Power control, only writable bits kept
  logic [7:0] igc_r; // Interrupt and general control
  logic [7:0] cscfg_r; // Status-change interrupt configuration
  logic compat_alt; // Alternate power layout in force
  logic [7:0] pwr_mask; // Writable and readable power bits of this layout

  // Revision value 0010b switches the power register layout
  assign compat_alt = (id_r[3:0] == spic_pkg::COMPAT_REV); // [R11]
  // Reserved positions differ per layout
  assign pwr_mask = compat_alt ? spic_pkg::PWR_MASK_ALT :
    spic_pkg::PWR_MASK_DEF; // [R3] [R9] [R10]

  // ==========================================================================
  // Identification register, top two bits hardwired
  always_ff @(posedge clk)
  begin
    if (reset)
      id_r <= spic_pkg::ID_RESET;
    else if (wr_en && offset == spic_pkg::IDX_ID)
      id_r <= spic_pkg::ID_FIXED | (wdata & spic_pkg::ID_RW_MASK);
  end

  // Power control; reserved data is dropped on the way in
  always_ff @(posedge clk)
  begin
    if (reset)
      pwr_r <= spic_pkg::REG_RESET;
    else if (wr_en && offset == spic_pkg::IDX_PWR)
      pwr_r <= wdata & pwr_mask; // [R19]
  end

  // Interrupt and general control, fully writable
  always_ff @(posedge clk)
  begin
    if (reset)
      igc_r <= spic_pkg::REG_RESET;
    else if (wr_en && offset == spic_pkg::IDX_IGC)
      igc_r <= wdata;
  end

  // Status-change interrupt configuration, fully writable
  always_ff @(posedge clk)
  begin
    if (reset)
      cscfg_r <= spic_pkg::REG_RESET;
    else if (wr_en && offset == spic_pkg::IDX_CSCFG)
      cscfg_r <= wdata;
  end

  // ==========================================================================
  // Control decode
  always_comb
  begin
    ctrl = '0;
    ctrl.alt = compat_alt;
    ctrl.out_en = pwr_r[spic_pkg::PWR_COE]; // [R2]
    if (compat_alt)
    begin
      // Bits 4..3: 10 is 5 V, 11 is 3.3 V, others leave Vcc off
      ctrl.vcc_on = pwr_r[spic_pkg::PWR_VCCEN]; // [R8]
      // Only code 11 means 3.3 V; the reserved code 01 leaves it clear
      ctrl.vcc_3v3 = pwr_r[spic_pkg::PWR_VCCEN] &
        pwr_r[spic_pkg::PWR_VCC_LO]; // [R8]
    end
    else
    begin
      // Auto switching holds Vcc off until the card is seated
      ctrl.vcc_on = pwr_r[spic_pkg::PWR_VCCEN] &
        (~pwr_r[spic_pkg::PWR_AUTO] | card_present); // [R4] [R5]
      ctrl.vcc_3v3 = sys_vcc_sel; // [R5]
    end
    // Vpp acts only with Vcc on; the reserved code drives nothing
    if (ctrl.vcc_on && pwr_r[1:0] != spic_pkg::VPP_RSVD)
      ctrl.vpp = pwr_r[1:0]; // [R6] [R7]
    else
      ctrl.vpp = spic_pkg::VPP_NONE; // [R6] [R7]
    ctrl.card_reset = ~igc_r[spic_pkg::IGC_RST]; // [R14]
    ctrl.ring_en = igc_r[spic_pkg::IGC_RING]; // [R13]
    ctrl.io_card = igc_r[spic_pkg::IGC_TYPE]; // [R15]
    // Select code zero also sends status changes to PCI
    ctrl.csc_pci = igc_r[spic_pkg::IGC_CSC] |
      (igc_r[3:0] == spic_pkg::FSEL_NONE); // [R16] [R17]
    ctrl.csc_sel = cscfg_r[7:4]; // [R16]
    ctrl.func_sel = igc_r[3:0]; // [R18]
  end

  // ==========================================================================
  // Read mux, unknown offsets read zero
  always_comb
  begin
    rdata = spic_pkg::REG_RESET;
    unique case (offset)
      spic_pkg::IDX_ID: rdata = id_r;
      spic_pkg::IDX_STAT: rdata[spic_pkg::STAT_PWR] = ctrl.vcc_on; // [R12]
      spic_pkg::IDX_PWR: rdata = pwr_r & pwr_mask; // [R3] [R9] [R10]
      spic_pkg::IDX_IGC: rdata = igc_r;
      spic_pkg::IDX_CSCFG: rdata = cscfg_r;
      default: rdata = spic_pkg::REG_RESET;
    endcase
  end

endmodule

`default_nettype wire

// >>> dv/spic_card_model.sv
// Behavioural model of one 16-bit card sitting in a socket
`timescale 1ns/1ps
`default_nettype none

module spic_card_model
(
  input wire logic inserted,
  input wire logic ring,
  input wire logic irq,
  output logic [1:0] card_detect_n,
  output logic battery_ring,
  output logic irq_n
);
  // ==========================================================================
  // Card-side pins
  // An empty socket leaves every line to its pull-up, so a stale level
  // from the last card can never pass for a live one
  always_comb
  begin
    card_detect_n = inserted ? 2'h0 : 2'h3;
    battery_ring = inserted ? ring : 1'b1;
    irq_n = inserted ? !irq : 1'b1;
  end
endmodule
`default_nettype wire

// >>> dv/test_spic_top.sv
// Self-checking bench for the two-socket power and interrupt control block
`timescale 1ns/1ps
`default_nettype none

module test_spic_top;
  // ==========================================================================
  // Stimulus and observed signals
  logic sys_clk = 1'b0; // 100 MHz system clock
  logic reset = 1'b1;
  logic [13:0] adr = 14'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [1:0] ins = 2'h3; // Both cards seated
  logic [1:0] rng = 2'h3; // Ring lines active
  logic [1:0] irq = 2'h0; // Card interrupt requests
  logic [3:0] cd_n;
  logic [1:0] bri, irq_n, oe_n, crst, vcc, v33, ringo, cscp;
  logic [31:0] rdat;
  logic waitreq;
  logic [3:0] vpp;
  logic [7:0] cscs;
  logic [15:0] irql;
  int error_cnt = 0;
  int total_checks = 0;

  // ==========================================================================
  // Design and the two cards
  spic_top u_dut (.SYS_CLK(sys_clk), .RESET(reset), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
    .CARD_DETECT_N(cd_n), .BATTERY_RING_IN(bri), .CARD_IREQ_N(irq_n),
    .CARD_OE_N(oe_n), .CARD_RESET(crst), .VCC_ON(vcc), .VCC_SEL_3V3(v33),
    .VPP_SEL(vpp), .RING_INDICATE(ringo), .CSC_TO_PCI(cscp),
    .CSC_IRQ_SEL(cscs), .IRQ_LINES(irql));
  spic_card_model u_card_a (.inserted(ins[0]), .ring(rng[0]),
    .irq(irq[0]), .card_detect_n(cd_n[1:0]), .battery_ring(bri[0]),
    .irq_n(irq_n[0]));
  spic_card_model u_card_b (.inserted(ins[1]), .ring(rng[1]),
    .irq(irq[1]), .card_detect_n(cd_n[3:2]), .battery_ring(bri[1]),
    .irq_n(irq_n[1]));

  // Clock source
  initial
  begin
    forever #5 sys_clk = !sys_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  end
  endtask

  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [13:0] a,
    input logic [7:0] d, input logic [3:0] e, output logic [7:0] q);
    int n;
  begin
    n = 0;
    @(posedge sys_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    be <= e;
    wdat <= {24'h000000, d};
    @(posedge sys_clk);
    while (waitreq !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20)
      check("bus answer", 32'h1, 32'h0);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  end
  endtask

  // Write, then let the registered pins follow
  task automatic wreg(input logic [13:0] a, input logic [7:0] d);
    logic [7:0] q;
  begin
    bus(1'b1, a, d, 4'hF, q);
    repeat (5) @(posedge sys_clk);
  end
  endtask

  task automatic rchk(input string what, input logic [13:0] a,
    input logic [7:0] e);
    logic [7:0] q;
  begin
    bus(1'b0, a, 8'h00, 4'hF, q);
    check(what, e, q);
  end
  endtask

  // Card pins need the synchroniser plus output flop
  task automatic settle();
  begin
    repeat (5) @(posedge sys_clk);
  end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
  begin
    check("oe_n", 2'h3, oe_n);
    check("card reset", 2'h3, crst);
    check("vcc", 2'h0, vcc);
    check("ring", 2'h0, ringo);
    check("csc pci", 2'h3, cscp);
    rchk("pwr a", 14'h0008, 8'h00);
    rchk("gen b", 14'h010C, 8'h00);
  end
  endtask

  task automatic t_default();
    logic [7:0] q;
  begin
    wreg(14'h0008, 8'hFF);
    rchk("pwr mask", 14'h0008, 8'hB3);
    check("vcc auto", 2'h1, vcc);
    check("vpp rsvd", 4'h0, vpp);
    check("oe_n on", 2'h2, oe_n);
    check("5v", 2'h0, v33);
    rchk("stat on", 14'h0004, 8'h40);
    wreg(14'h0200, 8'h04);
    check("3v3", 2'h1, v33 & 2'h1);
    ins <= 2'h2;
    settle();
    check("vcc pulled", 2'h0, vcc);
    rchk("stat off", 14'h0004, 8'h00);
    wreg(14'h0008, 8'h11);
    check("vcc manual", 2'h1, vcc);
    check("vpp vcc", 4'h1, vpp);
    check("oe_n off", 2'h3, oe_n);
    ins <= 2'h3;
    wreg(14'h0008, 8'h12);
    check("vpp 12v", 4'h2, vpp);
    wreg(14'h0008, 8'h02);
    check("vpp no vcc", 4'h0, vpp);
    bus(1'b1, 14'h0008, 8'h80, 4'hE, q);
    rchk("lane off", 14'h0008, 8'h02);
    wreg(14'h0018, 8'hFF);
    rchk("unmapped", 14'h0018, 8'h00);
  end
  endtask

  task automatic t_alt();
    logic [1:0] c;
  begin
    wreg(14'h0000, 8'h02);
    wreg(14'h0008, 8'hFF);
    rchk("alt mask", 14'h0008, 8'h9B);
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      wreg(14'h0008, {3'h4, c, 3'h1});
      check("alt vcc", {1'b0, c[1]}, vcc);
      // Socket B stays in the default layout with the system select set
      check("alt 3v3", {1'b1, c == 2'h3}, v33);
      check("alt vpp", {3'h0, c[1]}, vpp);
    end
    wreg(14'h0000, 8'h04);
    wreg(14'h0008, 8'hFF);
    rchk("def again", 14'h0008, 8'hB3);
  end
  endtask

  task automatic t_general();
    logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9};
  begin
    wreg(14'h210C, 8'h65);
    check("ring off", 2'h0, ringo);
    check("rst off", 2'h1, crst);
    rchk("gen alias", 14'h010C, 8'h65);
    rchk("gen a", 14'h000C, 8'h00);
    wreg(14'h010C, 8'hE5);
    check("ring on", 2'h2, ringo);
    irq <= 2'h2;
    foreach (codes[i])
    begin
      wreg(14'h010C, {4'h6, codes[i]});
      check("irq line", 16'h0001 << codes[i], irql);
      check("csc ex", 2'h1, cscp);
    end
    wreg(14'h010C, 8'h45);
    check("mem card", 16'h0000, irql);
    wreg(14'h010C, 8'h60);
    check("sel none", 16'h0000, irql);
    check("csc none", 2'h3, cscp);
    wreg(14'h0114, 8'hA0);
    wreg(14'h010C, 8'h61);
    check("csc sel", 8'hA0, cscs);
    wreg(14'h010C, 8'h71);
    check("csc route", 2'h3, cscp);
    check("csc forced", 8'h00, cscs);
    irq <= 2'h0;
    settle();
    check("irq idle", 16'h0000, irql);
    // Socket A general control: release card reset, route status to PCI
    wreg(14'h000C, 8'h50);
    check("rst a", 2'h0, crst);
    check("csc a", 2'h3, cscp);
  end
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic end_sim();
  begin
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    t_reset();
    t_default();
    t_alt();
    t_general();
    end_sim();
  end
endmodule
`default_nettype wire
